// [core/vme_irq_handler.sv]
// Interrupt handler, bus arbiter and address decode of the VME side.
// Assumes boards answer on the backplane interface in the same clock.
// Contract
// - Three arbitration options, combinable; here round robin overrides slot priority, and bit 0 is not used
// - Reset to slot priority, non-CPU lowest first
// - Arbitration selection in processor read/write register
// - Monitor seven active-low request lines
// - Level seven highest, level one lowest
// - Same level: lowest slot wins acknowledge
// - Interrupter pulls exactly one request line
// - Processor acknowledge returned toward VME bus
// - Win bus mastership before acknowledge cycle
// - Drive acknowledge low, level on A03-A01
// - Acknowledge ripples slot to slot, lowest first
// - Interrupters sample level at acknowledge fall
// - Requester drives 8-bit status/ID on data
// - Status/ID delivered as one-of-256 vector
// - Decode registers hold upper 16 bits
// - First 16 bytes of A16 window reserved
// - Two windows preset to A16 and A32
// - Request, grant, hold busy until release
// - No bus-clear signal provided
`timescale 1ns/10ps
`default_nettype none
module vme_irq_handler
    import vme_ih_pkg::*;
#(
    parameter int NSLOT = 4,
    parameter logic [NSLOT-1:0] CPU_SLOTS_RST = '0
) (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_reg_we,
    input wire logic [IDX_W-1:0] i_reg_idx,
    input wire logic [REG_W-1:0] i_reg_wdata,
    output logic [REG_W-1:0] o_reg_rdata,
    input wire logic i_cpu_iack,
    output logic o_irq_pending,
    output logic [CODE_W-1:0] o_irq_level,
    output logic [VEC_W-1:0] o_vector,
    output logic o_vector_valid,
    input wire logic [31:0] i_cpu_addr,
    output logic [31:0] o_vme_addr,
    output logic [1:0] o_win_hit,
    output logic o_win_reserved,
    vme_link_if.handler bus
);
    localparam int SW = $clog2(NSLOT);
    // Configuration registers
    logic [2:0] arb_cfg_q; // Option enables
    logic [NSLOT-1:0] cpu_slots_q; // Slots holding processors
    logic [REG_W-1:0] win_q [6]; // Two window triples
    // Arbiter state
    arb_state_t arb_q, arb_d;
    logic [NSLOT-1:0] bg_q, bg_d;
    logic [SW-1:0] last_q, last_d; // Last slot granted
    logic own_q, own_d; // Handler holds the bus
    // Handler state
    ih_state_t ih_q, ih_d;
    logic [CODE_W-1:0] lvl_q, lvl_d;
    logic iack_n_q, iack_n_d;
    logic [CODE_W-1:0] code_q, code_d;
    logic [VEC_W-1:0] vec_q, vec_d;
    logic vec_v_q, vec_v_d;
    logic pend_q;
    logic [CODE_W-1:0] top_q;
    logic [REG_W-1:0] rdata_q;
    logic [31:0] vme_addr_q;
    logic [1:0] hit_q;
    logic rsv_q;
    // Request lines, active low on the bus, reversed so level 7 is bit 0
    logic [NUM_LEVELS-1:0] lvl_rev;
    logic irq_any;
    logic [2:0] lvl_idx;
    logic [CODE_W-1:0] top_lvl;
    always_comb begin
        for (int k = 0; k < NUM_LEVELS; k++) begin
            lvl_rev[k] = ~bus.irq_n[NUM_LEVELS - k];
        end
    end
    vme_first_set #(.W(NUM_LEVELS)) u_lvl (
        .i_vec(lvl_rev),
        .o_any(irq_any),
        .o_idx(lvl_idx)
    );
    assign top_lvl = CODE_W'(7) - lvl_idx;
    // Slot candidates: rotating window or non-processor slots first
    logic [NSLOT-1:0] above, cand_a, cand;
    logic cand_a_any, br_any;
    logic [SW-1:0] pick_a, pick_b, pick;
    always_comb begin
        for (int i = 0; i < NSLOT; i++) begin
            above[i] = (SW'(i) > last_q);
        end
    end
    assign cand_a = arb_cfg_q[ARB_RR_BIT] ? (bus.br_v & above)
                  : (bus.br_v & ~cpu_slots_q);
    vme_first_set #(.W(NSLOT)) u_slot_a (
        .i_vec(cand_a),
        .o_any(cand_a_any),
        .o_idx(pick_a)
    );
    assign cand = bus.br_v;
    vme_first_set #(.W(NSLOT)) u_slot_b (
        .i_vec(cand),
        .o_any(br_any),
        .o_idx(pick_b)
    );
    assign pick = cand_a_any ? pick_a : pick_b;
    logic self_req, ih_done, ror;
    assign self_req = (ih_q == IH_BUS) && !own_q;
    assign ih_done = (ih_q == IH_END) && !bus.dtack_any;
    assign ror = arb_cfg_q[ARB_ROR_BIT];
    // Arbiter; the current master is never asked to let go early
    always_comb begin
        arb_d = arb_q;
        bg_d = bg_q;
        last_d = last_q;
        own_d = own_q;
        case (arb_q)
            ARB_IDLE: begin
                if (own_q) begin
                    // Parked handler lets go when its cycle ends with ror clear, or with ror set, when idle and a board requests
                    if (ih_done && !ror) begin
                        own_d = 1'b0;
                    end else if (ror && br_any && ih_q == IH_IDLE) begin
                        own_d = 1'b0;
                    end
                end else if (self_req && !bus.brd_bbsy) begin
                    own_d = 1'b1;
                end else if (br_any && !bus.brd_bbsy) begin
                    bg_d = NSLOT'(1) << pick;
                    last_d = pick;
                    arb_d = ARB_GRANT;
                end
            end
            ARB_GRANT: begin
                // Grant stands until the winner shows busy
                if (bus.brd_bbsy) begin
                    bg_d = '0;
                    arb_d = ARB_HELD;
                end
            end
            ARB_HELD: begin
                if (!bus.brd_bbsy) begin
                    arb_d = ARB_IDLE;
                end
            end
            default: arb_d = ARB_IDLE;
        endcase
    end
    // Acknowledge sequence toward the backplane
    always_comb begin
        ih_d = ih_q;
        lvl_d = lvl_q;
        iack_n_d = iack_n_q;
        code_d = code_q;
        vec_d = vec_q;
        vec_v_d = 1'b0;
        case (ih_q)
            IH_IDLE: begin
                if (irq_any && i_cpu_iack) begin
                    lvl_d = top_lvl;
                    ih_d = IH_BUS;
                end
            end
            IH_BUS: begin
                if (own_q) begin
                    code_d = lvl_q;
                    ih_d = IH_ADDR;
                end
            end
            IH_ADDR: begin
                // Code stood a cycle, so the fall marks it valid
                iack_n_d = 1'b0;
                ih_d = IH_STROBE;
            end
            IH_STROBE: begin
                // Chain order picks the lowest slot at this level
                if (bus.dtack_any) begin
                    vec_d = bus.data;
                    vec_v_d = 1'b1;
                    iack_n_d = 1'b1;
                    ih_d = IH_END;
                end
            end
            IH_END: begin
                if (!bus.dtack_any) begin
                    ih_d = IH_IDLE;
                end
            end
            default: ih_d = IH_IDLE;
        endcase
    end
    // Window decode on the upper half-word; the lower half-word feeds the reserved-byte check and passes through to the translated address
    logic [15:0] up;
    logic hit1, hit2, rsv;
    logic [31:0] vme_d;
    assign up = i_cpu_addr[31:16];
    assign hit1 = (up >= win_q[0]) && (up <= win_q[1]);
    assign hit2 = (up >= win_q[3]) && (up <= win_q[4]);
    assign rsv = hit1 && (up == win_q[0])
               && (i_cpu_addr[15:0] < A16_RSVD_BYTES);
    assign vme_d = (hit1 && !rsv) ? {up + win_q[2], i_cpu_addr[15:0]}
                 : (hit2 && !hit1) ? {up + win_q[5], i_cpu_addr[15:0]}
                 : 32'h0000_0000;
    // Register read mux
    logic [REG_W-1:0] rd_d;
    logic [3:0] wsel;
    assign wsel = i_reg_idx - REG_W1_LO;
    assign rd_d = (i_reg_idx == REG_ARB_CFG) ? REG_W'(arb_cfg_q)
                : (i_reg_idx == REG_CPU_SLOTS) ? REG_W'(cpu_slots_q)
                : (i_reg_idx >= REG_W1_LO && i_reg_idx <= REG_W2_XL)
                  ? win_q[wsel[2:0]]
                : (i_reg_idx == REG_STATUS)
                  ? {11'h000, own_q, pend_q, lvl_q}
                : 16'h0000;
    // Configuration writes; windows preset to the two default maps
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            arb_cfg_q <= ARB_CFG_RST;
            cpu_slots_q <= CPU_SLOTS_RST;
            win_q[0] <= W1_LO_RST;
            win_q[1] <= W1_HI_RST;
            win_q[2] <= W1_XL_RST;
            win_q[3] <= W2_LO_RST;
            win_q[4] <= W2_HI_RST;
            win_q[5] <= W2_XL_RST;
        end else if (i_reg_we) begin
            if (i_reg_idx == REG_ARB_CFG) begin
                arb_cfg_q <= i_reg_wdata[2:0];
            end else if (i_reg_idx == REG_CPU_SLOTS) begin
                cpu_slots_q <= i_reg_wdata[NSLOT-1:0];
            end else if (i_reg_idx >= REG_W1_LO && i_reg_idx <= REG_W2_XL) begin
                win_q[wsel[2:0]] <= i_reg_wdata;
            end
        end
    end
    // State and outputs
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            arb_q <= ARB_IDLE;
            bg_q <= '0;
            last_q <= '0;
            own_q <= 1'b0;
            ih_q <= IH_IDLE;
            lvl_q <= '0;
            iack_n_q <= 1'b1;
            code_q <= '0;
            vec_q <= '0;
            vec_v_q <= 1'b0;
        end else begin
            arb_q <= arb_d;
            bg_q <= bg_d;
            last_q <= last_d;
            own_q <= own_d;
            ih_q <= ih_d;
            lvl_q <= lvl_d;
            iack_n_q <= iack_n_d;
            code_q <= code_d;
            vec_q <= vec_d;
            vec_v_q <= vec_v_d;
        end
    end
    // Registered views for the processor
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            pend_q <= 1'b0;
            top_q <= '0;
            rdata_q <= '0;
            vme_addr_q <= '0;
            hit_q <= '0;
            rsv_q <= 1'b0;
        end else begin
            pend_q <= irq_any;
            top_q <= top_lvl;
            rdata_q <= rd_d;
            vme_addr_q <= vme_d;
            hit_q <= {hit2 && !hit1, hit1 && !rsv};
            rsv_q <= rsv;
        end
    end
    assign o_reg_rdata = rdata_q;
    assign o_irq_pending = pend_q;
    assign o_irq_level = top_q;
    assign o_vector = vec_q;
    assign o_vector_valid = vec_v_q;
    assign o_vme_addr = vme_addr_q;
    assign o_win_hit = hit_q;
    assign o_win_reserved = rsv_q;
    // Backplane drive; no bus-clear line exists on this arbiter
    assign bus.bg = bg_q;
    assign bus.iack_n = iack_n_q;
    assign bus.a_code = code_q;
    assign bus.h_bbsy = own_q;
endmodule // vme_irq_handler
`default_nettype wire

// [core/vme_ih_pkg.sv]
// Shared constants and state types for the VME interrupt handler,
// the bus arbiter and the interrupter boards in the backplane.
// Assumes every user is clocked by one reference clock.
package vme_ih_pkg;
    localparam int NUM_LEVELS = 7; // Request lines 1..7
    localparam int CODE_W = 3; // Level code on A03..A01
    localparam int VEC_W = 8; // Status/ID width used here
    localparam int REG_W = 16; // Register data width
    localparam int IDX_W = 4; // Register index width
    // Register indexes on the processor configuration port
    localparam logic [3:0] REG_ARB_CFG = 4'h0;
    localparam logic [3:0] REG_CPU_SLOTS = 4'h1;
    localparam logic [3:0] REG_W1_LO = 4'h2;
    localparam logic [3:0] REG_W1_HI = 4'h3;
    localparam logic [3:0] REG_W1_XL = 4'h4;
    localparam logic [3:0] REG_W2_LO = 4'h5;
    localparam logic [3:0] REG_W2_HI = 4'h6;
    localparam logic [3:0] REG_W2_XL = 4'h7;
    localparam logic [3:0] REG_STATUS = 4'h8;
    // Arbitration option bits
    localparam int ARB_SLOT_BIT = 0;
    localparam int ARB_RR_BIT = 1;
    localparam int ARB_ROR_BIT = 2;
    localparam logic [2:0] ARB_CFG_RST = 3'h1;
    // Window reset values, upper 16 address bits only
    localparam logic [15:0] W1_LO_RST = 16'hC100;
    localparam logic [15:0] W1_HI_RST = 16'hC100;
    localparam logic [15:0] W1_XL_RST = 16'h3EFF;
    localparam logic [15:0] W2_LO_RST = 16'hC101;
    localparam logic [15:0] W2_HI_RST = 16'hE0BF;
    localparam logic [15:0] W2_XL_RST = 16'h1EFF;
    localparam logic [15:0] A16_RSVD_BYTES = 16'h0010;
    typedef enum logic [1:0] {ARB_IDLE, ARB_GRANT, ARB_HELD} arb_state_t;
    typedef enum logic [2:0] {
        IH_IDLE, IH_BUS, IH_ADDR, IH_STROBE, IH_END
    } ih_state_t;
endpackage

// [core/vme_link_if.sv]
// Backplane between the handler/arbiter and NSLOT interrupter boards.
// Resolves wired-OR request, busy, data and acknowledge lines here.
`timescale 1ns/10ps
`default_nettype none
interface vme_link_if #(parameter int NSLOT = 4);
    // Board side, one element per slot
    logic [7:1] irq_oe [NSLOT]; // Pulls a request line low
    logic br [NSLOT]; // Bus request
    logic bbsy [NSLOT]; // Bus busy
    logic dtack [NSLOT]; // Status/ID on data lines
    logic d_oe [NSLOT]; // Data drive enable
    logic [7:0] d_out [NSLOT]; // Data driven
    logic iackout_n [NSLOT]; // Daisy-chain output
    // Handler side
    logic [NSLOT-1:0] bg; // Per-slot grants
    logic iack_n; // Acknowledge strobe
    logic [2:0] a_code; // A03..A01
    logic h_bbsy; // Handler owns bus
    // Resolved lines
    logic [7:1] irq_n;
    logic [NSLOT-1:0] br_v;
    logic brd_bbsy;
    logic dtack_any;
    logic [7:0] data;
    logic iackin_n [NSLOT];
    always_comb begin
        irq_n = 7'h7F;
        brd_bbsy = 1'b0;
        dtack_any = 1'b0;
        data = 8'h00;
        for (int s = 0; s < NSLOT; s++) begin
            irq_n = irq_n & ~irq_oe[s];
            br_v[s] = br[s];
            brd_bbsy = brd_bbsy | bbsy[s];
            dtack_any = dtack_any | dtack[s];
            if (d_oe[s]) begin
                data = data | d_out[s];
            end
            iackin_n[s] = (s == 0) ? iack_n : iackout_n[s-1];
        end
    end
    modport handler (
        input irq_n, br_v, brd_bbsy, dtack_any, data,
        output bg, iack_n, a_code, h_bbsy
    );
    modport board (
        input bg, a_code, iackin_n,
        output irq_oe, br, bbsy, dtack, d_oe, d_out, iackout_n
    );
endinterface
`default_nettype wire

// [core/vme_first_set.sv]
// Finds the lowest set bit of a vector; purely combinational.
// Assumes the caller registers whatever it derives from the index.
`timescale 1ns/10ps
`default_nettype none
module vme_first_set #(
    parameter int W = 8
) (
    input wire logic [W-1:0] i_vec,
    output logic o_any,
    output logic [$clog2(W)-1:0] o_idx
);
    // Scan from the top so the lowest bit wins last
    always_comb begin
        o_any = |i_vec;
        o_idx = '0;
        for (int i = W - 1; i >= 0; i--) begin
            if (i_vec[i]) begin
                o_idx = ($clog2(W))'(i);
            end
        end
    end
endmodule // vme_first_set
`default_nettype wire

// [core/vme_interrupter.sv]
// One interrupter and bus-master board in backplane slot SLOT.
// Assumes the same clock as the handler; chain input is synchronous.
`timescale 1ns/10ps
`default_nettype none
module vme_interrupter
    import vme_ih_pkg::*;
#(
    parameter int SLOT = 0,
    parameter int NSLOT = 4
) (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_raise,
    input wire logic [CODE_W-1:0] i_level,
    input wire logic [VEC_W-1:0] i_status_id,
    output logic o_irq_busy,
    output logic o_acked,
    input wire logic i_bus_want,
    output logic o_bus_owned,
    vme_link_if.board bus
);
    logic pend_q; // Request outstanding
    logic [CODE_W-1:0] lvl_q; // Requested level
    logic [VEC_W-1:0] sid_q; // Status/ID to return
    logic [7:1] irq_oe_q; // One-hot line pull
    logic drive_q; // Answering the acknowledge
    logic pass_n_q; // Chain output, active low
    logic prev_q; // Chain input last cycle
    logic acked_q;
    logic br_q, own_q;
    logic fall, mine;
    assign fall = prev_q && !bus.iackin_n[SLOT];
    assign mine = pend_q && (bus.a_code == lvl_q);
    // Request and acknowledge handling
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            pend_q <= 1'b0;
            lvl_q <= '0;
            sid_q <= '0;
            irq_oe_q <= '0;
            drive_q <= 1'b0;
            pass_n_q <= 1'b1;
            prev_q <= 1'b1;
            acked_q <= 1'b0;
        end else begin
            prev_q <= bus.iackin_n[SLOT];
            acked_q <= 1'b0;
            if (!pend_q && i_raise && i_level != '0) begin
                // Only one line is ever pulled
                pend_q <= 1'b1;
                lvl_q <= i_level;
                sid_q <= i_status_id;
                irq_oe_q <= 7'(7'h01 << (i_level - 3'h1));
            end
            if (fall) begin
                if (mine) begin
                    drive_q <= 1'b1;
                end else begin
                    pass_n_q <= 1'b0;
                end
            end else if (bus.iackin_n[SLOT]) begin
                pass_n_q <= 1'b1;
                drive_q <= 1'b0;
                if (drive_q) begin
                    // Accepted: drop the line so it is not taken twice
                    pend_q <= 1'b0;
                    irq_oe_q <= '0;
                    acked_q <= 1'b1;
                end
            end
        end
    end
    // Mastership: request, take grant, hold busy until done
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            br_q <= 1'b0;
            own_q <= 1'b0;
        end else if (own_q) begin
            own_q <= i_bus_want;
        end else if (br_q && bus.bg[SLOT]) begin
            br_q <= 1'b0;
            own_q <= 1'b1;
        end else begin
            br_q <= i_bus_want;
        end
    end
    assign o_irq_busy = pend_q;
    assign o_acked = acked_q;
    assign o_bus_owned = own_q;
    assign bus.irq_oe[SLOT] = irq_oe_q;
    assign bus.br[SLOT] = br_q;
    assign bus.bbsy[SLOT] = own_q;
    assign bus.dtack[SLOT] = drive_q;
    assign bus.d_oe[SLOT] = drive_q;
    assign bus.d_out[SLOT] = sid_q;
    assign bus.iackout_n[SLOT] = pass_n_q;
endmodule // vme_interrupter
`default_nettype wire

// [tb/vme_ih_monitor.sv]
// Protocol checker for the backplane between handler and interrupters.
// Assumes it watches the resolved interface lines on the one clock.
`timescale 1ns/10ps
`default_nettype none
module vme_ih_monitor #(
    parameter int NSLOT = 4
) (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic [7:1] irq_n,
    input wire logic [NSLOT-1:0] bg,
    input wire logic [NSLOT-1:0] br_v,
    input wire logic iack_n,
    input wire logic [2:0] a_code,
    input wire logic h_bbsy,
    input wire logic brd_bbsy,
    input wire logic dtack_any,
    input wire logic [7:0] data
);
    // Highest level whose request line is pulled low
    function automatic logic [2:0] top_of(input logic [7:1] v);
        logic [2:0] r;
        r = 3'h0;
        for (int i = 1; i < 8; i++) begin
            if (!v[i]) begin
                r = 3'(i);
            end
        end
        return r;
    endfunction

    wire logic [2:0] top_lvl; // Winning level seen on the lines
    assign top_lvl = top_of(irq_n);

    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);

    chk_grant_onehot: assert property ($onehot0(bg))
        else $error("more than one bus grant at once");
    chk_grant_cause: assert property ($rose(|bg) |-> $past(|br_v))
        else $error("grant without a pending bus request");
    chk_iack_level: assert property ($fell(iack_n) |-> a_code == top_lvl)
        else $error("acknowledge carries wrong level code");
    chk_iack_bus: assert property (!iack_n |-> h_bbsy && !brd_bbsy)
        else $error("acknowledge driven without bus ownership");
    chk_iack_hold: assert property ((!iack_n && !dtack_any) |=> !iack_n)
        else $error("acknowledge lifted before any answer");
    chk_iack_release: assert property ((!iack_n && dtack_any) |-> ##[1:2] iack_n)
        else $error("acknowledge not lifted after the answer");
    chk_dtack_drops: assert property ($rose(iack_n) |-> ##[1:NSLOT] !dtack_any)
        else $error("responder keeps answering after release");
    chk_code_stable: assert property ((!iack_n && !$past(iack_n)) |-> $stable(a_code))
        else $error("level code moved during acknowledge");

    // Main scenarios reached
    cover property ($fell(iack_n));
    cover property ($rose(|bg));
    cover property (dtack_any && data != 8'h00);
endmodule // vme_ih_monitor
`default_nettype wire

// [tb/vme_interrupt_handler_arbiter_tb.sv]
// Self-checking bench: handler plus four interrupter boards on one link.
// Assumes the design package, interface and modules are compiled first.
`timescale 1ns/10ps
`default_nettype none
`define CHECK_EQ(got, exp, msg) \
    begin \
        n_compared++; \
        if ((got) !== (exp)) begin \
            failures++; \
            $display("MISMATCH t=%0t %s", $time, msg); \
        end \
    end
module vme_interrupt_handler_arbiter_tb;
    import vme_ih_pkg::*;
    localparam int NS = 4; // Backplane slots
    logic i_ref_clk, i_rst, i_reg_we, i_cpu_iack;
    logic [IDX_W-1:0] i_reg_idx;
    logic [REG_W-1:0] i_reg_wdata, o_reg_rdata;
    logic o_irq_pending, o_vector_valid, o_win_reserved;
    logic [CODE_W-1:0] o_irq_level;
    logic [VEC_W-1:0] o_vector;
    logic [31:0] i_cpu_addr, o_vme_addr;
    logic [1:0] o_win_hit;
    logic [NS-1:0] raise_v, want_v, owned; // Per-board controls
    logic [2:0] lvl_v [NS];
    logic [7:0] id_v [NS];
    int failures = 0;
    int n_compared = 0;

    vme_link_if #(.NSLOT(NS)) link ();
    vme_irq_handler #(.NSLOT(NS)) vme_irq_handler_i (
        .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_reg_we(i_reg_we),
        .i_reg_idx(i_reg_idx), .i_reg_wdata(i_reg_wdata),
        .o_reg_rdata(o_reg_rdata), .i_cpu_iack(i_cpu_iack),
        .o_irq_pending(o_irq_pending), .o_irq_level(o_irq_level),
        .o_vector(o_vector), .o_vector_valid(o_vector_valid),
        .i_cpu_addr(i_cpu_addr), .o_vme_addr(o_vme_addr),
        .o_win_hit(o_win_hit), .o_win_reserved(o_win_reserved), .bus(link));
    // One board per slot, lowest slot first on the chain
    for (genvar g = 0; g < NS; g++) begin : g_slot
        vme_interrupter #(.SLOT(g), .NSLOT(NS)) vme_interrupter_i (
            .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_raise(raise_v[g]),
            .i_level(lvl_v[g]), .i_status_id(id_v[g]), .o_irq_busy(),
            .o_acked(), .i_bus_want(want_v[g]), .o_bus_owned(owned[g]),
            .bus(link));
    end
    vme_ih_monitor #(.NSLOT(NS)) vme_ih_monitor_i (
        .i_ref_clk(i_ref_clk), .i_rst(i_rst), .irq_n(link.irq_n),
        .bg(link.bg), .br_v(link.br_v), .iack_n(link.iack_n),
        .a_code(link.a_code), .h_bbsy(link.h_bbsy),
        .brd_bbsy(link.brd_bbsy), .dtack_any(link.dtack_any),
        .data(link.data));

    // Free-running reference clock, 40 ns period
    initial begin
        i_ref_clk = 1'b0;
        forever #20 i_ref_clk = ~i_ref_clk;
    end

    task automatic end_sim();
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Register write: one-cycle strobe
    task automatic reg_wr(input logic [3:0] idx, input logic [15:0] d);
        @(posedge i_ref_clk);
        i_reg_we <= 1'b1;
        i_reg_idx <= idx;
        i_reg_wdata <= d;
        @(posedge i_ref_clk);
        i_reg_we <= 1'b0;
    endtask

    // Register read: data one cycle after the index
    task automatic reg_rd(input logic [3:0] idx, input logic [15:0] exp);
        @(posedge i_ref_clk);
        i_reg_idx <= idx;
        @(posedge i_ref_clk);
        #1;
        `CHECK_EQ(o_reg_rdata, exp, "register read")
    endtask

    // Decode is registered one cycle; a miss translates to zero
    task automatic dec(input logic [31:0] a, input logic [1:0] hit,
                       input logic rsv, input logic [31:0] vme);
        @(posedge i_ref_clk);
        i_cpu_addr <= a;
        @(posedge i_ref_clk);
        #1;
        `CHECK_EQ(o_win_hit, hit, "window hit")
        `CHECK_EQ(o_win_reserved, rsv, "reserved bytes")
        `CHECK_EQ(o_vme_addr, vme, "translated address")
    endtask

    // Set up one board's request; the caller owns the strobe edge
    task automatic raise(input int s, input logic [2:0] l,
                         input logic [7:0] id);
        raise_v[s] <= 1'b1;
        lvl_v[s] <= l;
        id_v[s] <= id;
    endtask

    // Processor acknowledge, then wait for the fetched status/ID
    task automatic ack(input logic [7:0] exp);
        int n;
        @(posedge i_ref_clk);
        i_cpu_iack <= 1'b1;
        @(posedge i_ref_clk);
        i_cpu_iack <= 1'b0;
        #1;
        n = 0;
        while (o_vector_valid !== 1'b1 && n < 40) begin
            @(posedge i_ref_clk);
            #1;
            n++;
        end
        `CHECK_EQ(o_vector, exp, "status/ID vector")
        n = 0;
        // Next acknowledge only once the answer has gone away
        while (link.dtack_any !== 1'b0 && n < 10) begin
            @(posedge i_ref_clk);
            n++;
        end
        repeat (3) @(posedge i_ref_clk);
    endtask

    // Ask for the bus with a set of boards; bounded wait for the winner
    task automatic bus_win(input logic [3:0] want, input logic [3:0] exp);
        int n;
        @(posedge i_ref_clk);
        want_v <= want;
        n = 0;
        while (owned !== exp && n < 30) begin
            @(posedge i_ref_clk);
            #1;
            n++;
        end
        `CHECK_EQ(owned, exp, "bus owner")
    endtask

    // Watchdog: the whole run needs well under 3000 cycles
    initial begin
        repeat (6000) @(posedge i_ref_clk);
        failures++;
        end_sim();
    end

    initial begin
        logic [15:0] rst_tab [8];
        rst_tab = '{{13'h0, ARB_CFG_RST}, 16'h0000, W1_LO_RST, W1_HI_RST,
                    W1_XL_RST, W2_LO_RST, W2_HI_RST, W2_XL_RST};
        i_rst = 1'b1;
        i_reg_we = 1'b0;
        i_reg_idx = 4'h0;
        i_reg_wdata = 16'h0000;
        i_cpu_iack = 1'b0;
        i_cpu_addr = 32'h0000_0000;
        raise_v = 4'h0;
        want_v = 4'h0;
        for (int s = 0; s < NS; s++) begin
            lvl_v[s] = 3'h0;
            id_v[s] = 8'h00;
        end
        repeat (3) @(posedge i_ref_clk);
        i_rst <= 1'b0;
        // Reset values and unmapped places
        for (int i = 0; i < 8; i++) begin
            reg_rd(4'(i), rst_tab[i]);
        end
        reg_rd(4'h9, 16'h0000);
        reg_wr(4'hF, 16'hFFFF);
        reg_rd(4'hF, 16'h0000);
        $display("test registers_reset done");
        // Read/write of arbitration options and a window register
        reg_wr(REG_ARB_CFG, 16'h0007);
        reg_rd(REG_ARB_CFG, 16'h0007);
        reg_wr(REG_ARB_CFG, 16'h0001);
        reg_wr(REG_W2_XL, 16'hABCD);
        reg_rd(REG_W2_XL, 16'hABCD);
        reg_wr(REG_W2_XL, W2_XL_RST);
        $display("test registers_rw done");
        // Address decode windows
        dec(32'hC100_0004, 2'b00, 1'b1, 32'h0000_0000);
        dec(32'hC100_0010, 2'b01, 1'b0, 32'hFFFF_0010);
        dec(32'hC101_2345, 2'b10, 1'b0, 32'hE000_2345);
        dec(32'h1234_0000, 2'b00, 1'b0, 32'h0000_0000);
        $display("test decode done");
        // Every level once, through different slots
        for (int l = 1; l < 8; l++) begin
            @(posedge i_ref_clk);
            raise(l % NS, 3'(l), 8'hA0 | 8'(l));
            @(posedge i_ref_clk);
            raise_v <= 4'h0;
            repeat (3) @(posedge i_ref_clk);
            #1;
            `CHECK_EQ(o_irq_level, 3'(l), "pending level")
            `CHECK_EQ(o_irq_pending, 1'b1, "pending flag")
            ack(8'hA0 | 8'(l));
        end
        $display("test all_levels done");
        // Two levels at once, then one level from two slots
        @(posedge i_ref_clk);
        raise(2, 3'h3, 8'h33);
        raise(1, 3'h5, 8'h55);
        @(posedge i_ref_clk);
        raise_v <= 4'h0;
        reg_wr(REG_STATUS, 16'hFFFF);
        reg_rd(REG_STATUS, 16'h000F);
        ack(8'h55);
        ack(8'h33);
        @(posedge i_ref_clk);
        raise(3, 3'h4, 8'h43);
        raise(1, 3'h4, 8'h41);
        @(posedge i_ref_clk);
        raise_v <= 4'h0;
        repeat (3) @(posedge i_ref_clk);
        ack(8'h41);
        ack(8'h43);
        $display("test contention done");
        // Slot priority skips processor slots; round robin moves on
        reg_wr(REG_CPU_SLOTS, 16'h0001);
        bus_win(4'b0011, 4'b0010);
        bus_win(4'b0001, 4'b0001);
        bus_win(4'b0000, 4'b0000);
        reg_wr(REG_ARB_CFG, 16'h0002);
        bus_win(4'b0101, 4'b0100);
        bus_win(4'b0000, 4'b0000);
        $display("test arbitration done");
        end_sim();
    end
endmodule // vme_interrupt_handler_arbiter_tb
`default_nettype wire
